// *** rtl/dpt_timer_top.sv ***
// Purpose: Two 8-bit period timers, cascade mode, two pulse outputs
// Assumes: AHB-Lite slave, zero wait states, hclk is the oscillator
// Notes: Operation
// Operation
// - Clear cascade gives two independent timers
// - Source is instruction cycle or pin edge
// - Count up, wrap to zero after match
// - Wrap sets that timer's match flag
// - Interrupt needs enable, peripheral enable, not disabled
// - Run enable clear holds count, no flag
// - Pin edges synchronised before counting
// - Cascade forms 16-bit counter with period pair
// - First source select drives cascaded counter
// - Cascade runs 16-bit only with both enables, low byte alone with first
// - Cascaded external pin sampled twice per cycle
// - Second output picks first or second timer
// - Ten-bit duty, zero to full range
// - Duty settings double-buffered against glitches
// - First output enable forces pin output
// - Second output enable forces pin likewise
// - Base select picks second output's timer
// - Period lasts period_value plus one cycles
// - Duty from high byte and low bits
// - Wrap loads active duty, reads return it
`timescale 1ns/100ps
`default_nettype none
module dpt_timer_top
  import dpt_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic count_pin_in,
  input wire logic pulse1_pin_in,
  output logic pulse1_pin_out,
  output logic pulse1_pin_oe,
  input wire logic pulse2_pin_in,
  output logic pulse2_pin_out,
  output logic pulse2_pin_oe,
  output logic irq_req
);

  // Word addresses
  localparam logic [6:0] A_MISC = {BANK_U, IDX_MISC};
  localparam logic [6:0] A_CORE = {BANK_U, IDX_CORE};
  localparam logic [6:0] A_PDIR = {BANK_U, IDX_PORT_DIR};
  localparam logic [6:0] A_PDAT = {BANK_U, IDX_PORT_DATA};
  localparam logic [6:0] A_PFLAGS = {BANK_1, IDX_PFLAGS};
  localparam logic [6:0] A_PEN = {BANK_1, IDX_PENABLES};
  localparam logic [6:0] A_CNT1 = {BANK_2, IDX_FIRST_COUNT};
  localparam logic [6:0] A_CNT2 = {BANK_2, IDX_SECOND_COUNT};
  localparam logic [6:0] A_PER1 = {BANK_2, IDX_FIRST_PERIOD};
  localparam logic [6:0] A_PER2 = {BANK_2, IDX_SECOND_PERIOD};
  localparam logic [6:0] A_D1L = {BANK_3, IDX_DUTY1_LOW};
  localparam logic [6:0] A_D2L = {BANK_3, IDX_DUTY2_LOW};
  localparam logic [6:0] A_D1H = {BANK_3, IDX_DUTY1_HIGH};
  localparam logic [6:0] A_D2H = {BANK_3, IDX_DUTY2_HIGH};
  localparam logic [6:0] A_TCA = {BANK_3, IDX_TCFG_A};
  localparam logic [6:0] A_TCB = {BANK_3, IDX_TCFG_B};

  // Whole block state
  typedef struct packed {
    logic [1:0] q; // Phase within instruction cycle
    logic sync1; // Pin synchroniser, first stage
    logic sync2; // Pin synchroniser, second stage
    logic samp; // Last sampled pin level
    logic [7:0] cnt1; // first_count
    logic [7:0] cnt2; // second_count
    logic [7:0] per1; // first_period
    logic [7:0] per2; // second_period
    logic [7:0] core; // core_irq_status storage
    logic [7:0] pflags; // peripheral_flags
    logic [7:0] pen; // peripheral_enables
    logic [7:0] tca; // timer_config_a
    logic [7:0] tcb; // timer_config_b
    logic [7:0] misc; // Global disable holder
    logic [7:0] pdir; // port_direction_bits, 1 = input
    logic [7:0] pdat; // Port output latch
    logic [9:0] duty1; // Master duty, first output
    logic [9:0] duty2; // Master duty, second output
    logic base2; // pulse2_base_select
    logic wrap1; // First timer wrapped last cycle
    logic wrap2; // Second timer wrapped last cycle
    logic irq; // Interrupt request
    logic p1_out; // First pin level
    logic p1_oe; // First pin enable
    logic p2_out; // Second pin level
    logic p2_oe; // Second pin enable
    logic wr_pend; // Write data phase pending
    logic [6:0] wr_addr; // Word address of pending write
    logic [31:0] rdata; // Read data
    logic rdy; // hreadyout
    logic resp; // hresp
  } dpt_state_s;

  localparam dpt_state_s ST_RST = '{
    core: RST_CORE, pflags: RST_PFLAGS, pen: RST_PENABLES, tca: RST_TCFG_A,
    tcb: RST_TCFG_B, misc: RST_MISC, pdir: RST_PORT_DIR, pdat: RST_PORT_DATA,
    cnt1: RST_COUNT, cnt2: RST_COUNT, per1: RST_PERIOD, per2: RST_PERIOD,
    duty1: RST_DUTY, duty2: RST_DUTY, rdy: 1'b1, default: '0};

  dpt_state_s s_reg;
  dpt_state_s s_next;

  // Pulse channel links
  dpt_pwm_if pwb [2] ();

  // Working values
  logic cascade; // pair_cascade_select
  logic run1; // first_run_enable
  logic run2; // second_run_enable
  logic samp_en; // Pin sampling moment
  logic ext_tick; // Synchronised falling edge
  logic tick_int; // Instruction cycle end
  logic tick1; // First timer clock
  logic tick2; // Second timer clock
  logic set1; // first_match_flag event
  logic set2; // second_match_flag event
  logic peif; // Any enabled match flag
  logic acc; // Valid address phase
  logic [6:0] a_word; // Address phase word address
  logic [7:0] rbyte; // Read mux result
  logic [15:0] c16; // Cascaded count
  logic [7:0] pins; // Port read view

  // Timer, flag, pin and bus next-state logic
  always_comb
  begin
    s_next = s_reg;
    s_next.wrap1 = 1'b0;
    s_next.wrap2 = 1'b0;
    set1 = 1'b0;
    set2 = 1'b0;
    cascade = s_reg.tca[BIT_CASCADE];
    run1 = s_reg.tcb[BIT_RUN1];
    run2 = s_reg.tcb[BIT_RUN2];
    c16 = {s_reg.cnt2, s_reg.cnt1};

    // Free-running phase counter
    s_next.q = s_reg.q + 2'h1;
    // internal tick once per instruction cycle
    tick_int = (s_reg.q == PHASE_LAST);

    s_next.sync1 = count_pin_in;
    s_next.sync2 = s_reg.sync1;
    samp_en = tick_int | (cascade & (s_reg.q == PHASE_MID));
    if (samp_en)
    begin
      s_next.samp = s_reg.sync2;
    end
    // falling edge of the sampled pin
    ext_tick = samp_en & s_reg.samp & ~s_reg.sync2;

    // each timer's own source select picks its clock
    tick1 = s_reg.tca[BIT_SRC1] ? ext_tick : tick_int;
    tick2 = s_reg.tca[BIT_SRC2] ? ext_tick : tick_int;

    if (cascade)
    begin
      if (run1 && tick1)
      begin
        if (!run2)
        begin
          // Low byte alone
          s_next.cnt1 = s_reg.cnt1 + 8'h01;
        end
        else if (c16 == {s_reg.per2, s_reg.per1})
        begin
          s_next.cnt1 = 8'h00;
          s_next.cnt2 = 8'h00;
          set1 = 1'b1;
          s_next.wrap1 = 1'b1;
        end
        else
        begin
          c16 = c16 + 16'h0001;
          s_next.cnt1 = c16[7:0];
          s_next.cnt2 = c16[15:8];
        end
      end
    end
    else
    begin
      if (run1 && tick1)
      begin
        if (s_reg.cnt1 == s_reg.per1)
        begin
          s_next.cnt1 = 8'h00;
          set1 = 1'b1;
          s_next.wrap1 = 1'b1;
        end
        else
        begin
          s_next.cnt1 = s_reg.cnt1 + 8'h01;
        end
      end
      if (run2 && tick2)
      begin
        if (s_reg.cnt2 == s_reg.per2)
        begin
          s_next.cnt2 = 8'h00;
          set2 = 1'b1;
          s_next.wrap2 = 1'b1;
        end
        else
        begin
          s_next.cnt2 = s_reg.cnt2 + 8'h01;
        end
      end
    end

    // Data phase of a write; overrides counting
    if (s_reg.wr_pend)
    begin
      case (s_reg.wr_addr)
        A_MISC: s_next.misc = hwdata[7:0];
        A_CORE: s_next.core = hwdata[7:0];
        A_PDIR: s_next.pdir = hwdata[7:0];
        A_PDAT: s_next.pdat = hwdata[7:0];
        A_PFLAGS: s_next.pflags = hwdata[7:0];
        A_PEN: s_next.pen = hwdata[7:0];
        A_CNT1: s_next.cnt1 = hwdata[7:0];
        A_CNT2: s_next.cnt2 = hwdata[7:0];
        A_PER1: s_next.per1 = hwdata[7:0];
        A_PER2: s_next.per2 = hwdata[7:0];
        A_D1L: s_next.duty1[1:0] = hwdata[7:6];
        A_D2L:
        begin
          s_next.duty2[1:0] = hwdata[7:6];
          s_next.base2 = hwdata[BIT_BASE2];
        end
        A_D1H: s_next.duty1[9:2] = hwdata[7:0];
        A_D2H: s_next.duty2[9:2] = hwdata[7:0];
        A_TCA: s_next.tca = hwdata[7:0];
        A_TCB: s_next.tcb = hwdata[7:0] & TCFG_B_RW_MASK;
        default: s_next.misc = s_reg.misc;
      endcase
    end

    // hardware set wins over software clear
    if (set1)
    begin
      s_next.pflags[BIT_FLAG1] = 1'b1;
    end
    if (set2)
    begin
      s_next.pflags[BIT_FLAG2] = 1'b1;
    end

    // enabled flag, peripheral enable, not disabled
    peif = (s_reg.pflags[BIT_FLAG1] & s_reg.pen[BIT_FLAG1])
         | (s_reg.pflags[BIT_FLAG2] & s_reg.pen[BIT_FLAG2]);
    s_next.irq = peif & s_reg.core[BIT_PERIPHERAL_IRQ_ENABLE] & ~s_reg.misc[BIT_GLOBAL_IRQ_DISABLE];

    // first pin forced out when enabled
    s_next.p1_oe = s_reg.tcb[BIT_PULSE_OUT1_ENABLE] | ~s_reg.pdir[BIT_PIN1];
    s_next.p1_out = s_reg.tcb[BIT_PULSE_OUT1_ENABLE] ? pwb[0].level : s_reg.pdat[BIT_PIN1];
    s_next.p2_oe = s_reg.tcb[BIT_PULSE_OUT2_ENABLE] | ~s_reg.pdir[BIT_PIN2];
    s_next.p2_out = s_reg.tcb[BIT_PULSE_OUT2_ENABLE] ? pwb[1].level : s_reg.pdat[BIT_PIN2];

    // Address phase decode
    acc = hsel & htrans[1] & hready & (hsize == HSIZE_WORD)
        & (haddr[1:0] == 2'h0) & (haddr[31:9] == 23'h000000);
    a_word = haddr[8:2];
    s_next.wr_pend = acc & hwrite;
    s_next.wr_addr = a_word;

    // Port view: pin levels at the two pulse positions
    pins = s_reg.pdat;
    pins[BIT_PIN1] = pulse1_pin_in;
    pins[BIT_PIN2] = pulse2_pin_in;

    // Read mux; duty reads show active latches
    case (a_word)
      A_MISC: rbyte = s_reg.misc;
      A_CORE: rbyte = {peif, s_reg.core[6:0]};
      A_PDIR: rbyte = s_reg.pdir;
      A_PDAT: rbyte = pins;
      A_PFLAGS: rbyte = s_reg.pflags;
      A_PEN: rbyte = s_reg.pen;
      A_CNT1: rbyte = s_reg.cnt1;
      A_CNT2: rbyte = s_reg.cnt2;
      A_PER1: rbyte = s_reg.per1;
      A_PER2: rbyte = s_reg.per2;
      A_D1L: rbyte = {pwb[0].duty_active[1:0], 6'h00};
      A_D2L: rbyte = {pwb[1].duty_active[1:0], s_reg.base2, 5'h00};
      A_D1H: rbyte = pwb[0].duty_active[9:2];
      A_D2H: rbyte = pwb[1].duty_active[9:2];
      A_TCA: rbyte = s_reg.tca;
      A_TCB: rbyte = s_reg.tcb;
      default: rbyte = 8'h00;
    endcase
    if (acc && !hwrite)
    begin
      s_next.rdata = {24'h000000, rbyte};
    end

    // Always ready, always OKAY
    s_next.rdy = 1'b1;
    s_next.resp = 1'b0;
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_reg <= ST_RST;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // Pulse channels
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_chan
      if (g == 0)
      begin : g_first
        // period from first timer and period
        assign pwb[g].wrap = s_reg.wrap1;
        assign pwb[g].pos = {s_reg.cnt1, s_reg.q};
        assign pwb[g].duty_master = s_reg.duty1;
      end
      else
      begin : g_second
        assign pwb[g].wrap = s_reg.base2 ? s_reg.wrap2 : s_reg.wrap1;
        assign pwb[g].pos = s_reg.base2 ? {s_reg.cnt2, s_reg.q} : {s_reg.cnt1, s_reg.q};
        assign pwb[g].duty_master = s_reg.duty2;
      end
      dpt_pwm_chan u_chan (
        .hclk(hclk),
        .hresetn(hresetn),
        .bus(pwb[g].chan)
      );
    end
  endgenerate

  // Outputs from flip-flops
  assign hreadyout = s_reg.rdy;
  assign hresp = s_reg.resp;
  assign hrdata = s_reg.rdata;
  assign pulse1_pin_out = s_reg.p1_out;
  assign pulse1_pin_oe = s_reg.p1_oe;
  assign pulse2_pin_out = s_reg.p2_out;
  assign pulse2_pin_oe = s_reg.p2_oe;
  assign irq_req = s_reg.irq;

endmodule : dpt_timer_top
`default_nettype wire

// *** rtl/dpt_pkg.sv ***
// Purpose: Shared constants for the dual period timer and pulse outputs
// Assumes: One hclk domain; oscillator period equals one hclk period
// Notes: Word address = {bank, index}; byte address = word address * 4
package dpt_pkg;

  // Oscillator periods per instruction cycle
  localparam int PHASES = 4;
  // Phase at which an instruction cycle ends
  localparam logic [1:0] PHASE_LAST = 2'h3;
  // Extra sampling phase in cascaded external mode
  localparam logic [1:0] PHASE_MID = 2'h1;
  // Duty value width
  localparam int DUTY_BITS = 10;

  // Register banks
  localparam logic [1:0] BANK_U = 2'h0;
  localparam logic [1:0] BANK_1 = 2'h1;
  localparam logic [1:0] BANK_2 = 2'h2;
  localparam logic [1:0] BANK_3 = 2'h3;

  // Register indexes
  localparam logic [4:0] IDX_MISC = 5'h06;
  localparam logic [4:0] IDX_CORE = 5'h07;
  localparam logic [4:0] IDX_PORT_DIR = 5'h08;
  localparam logic [4:0] IDX_PORT_DATA = 5'h09;
  localparam logic [4:0] IDX_FIRST_COUNT = 5'h10;
  localparam logic [4:0] IDX_DUTY1_LOW = 5'h10;
  localparam logic [4:0] IDX_SECOND_COUNT = 5'h11;
  localparam logic [4:0] IDX_DUTY2_LOW = 5'h11;
  localparam logic [4:0] IDX_DUTY1_HIGH = 5'h12;
  localparam logic [4:0] IDX_DUTY2_HIGH = 5'h13;
  localparam logic [4:0] IDX_FIRST_PERIOD = 5'h14;
  localparam logic [4:0] IDX_SECOND_PERIOD = 5'h15;
  localparam logic [4:0] IDX_PFLAGS = 5'h16;
  localparam logic [4:0] IDX_TCFG_A = 5'h16;
  localparam logic [4:0] IDX_PENABLES = 5'h17;
  localparam logic [4:0] IDX_TCFG_B = 5'h17;

  // Field positions
  localparam int BIT_PEIF = 7;
  localparam int BIT_PERIPHERAL_IRQ_ENABLE = 3;
  localparam int BIT_GLOBAL_IRQ_DISABLE = 4;
  localparam int BIT_CASCADE = 3;
  localparam int BIT_SRC2 = 1;
  localparam int BIT_SRC1 = 0;
  localparam int BIT_PULSE_OUT2_ENABLE = 5;
  localparam int BIT_PULSE_OUT1_ENABLE = 4;
  localparam int BIT_RUN2 = 1;
  localparam int BIT_RUN1 = 0;
  localparam int BIT_FLAG2 = 5;
  localparam int BIT_FLAG1 = 4;
  localparam int BIT_BASE2 = 5;
  localparam int BIT_PIN1 = 2;
  localparam int BIT_PIN2 = 3;

  // Reset values
  localparam logic [7:0] RST_CORE = 8'h00;
  localparam logic [7:0] RST_PFLAGS = 8'h02;
  localparam logic [7:0] RST_PENABLES = 8'h00;
  localparam logic [7:0] RST_TCFG_A = 8'h00;
  localparam logic [7:0] RST_TCFG_B = 8'h00;
  localparam logic [7:0] RST_MISC = 8'h00;
  localparam logic [7:0] RST_PORT_DIR = 8'hff;
  localparam logic [7:0] RST_PORT_DATA = 8'h00;
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [7:0] RST_PERIOD = 8'h00;
  localparam logic [9:0] RST_DUTY = 10'h000;

  // Writable bits of timer_config_b; overflow bits read zero
  localparam logic [7:0] TCFG_B_RW_MASK = 8'h3f;
  // Only whole-word transfers are mapped
  localparam logic [2:0] HSIZE_WORD = 3'h2;

endpackage : dpt_pkg

// *** rtl/dpt_pwm_if.sv ***
// Purpose: Link between timer core and one pulse output channel
// Assumes: Single hclk domain
// Notes: One instance per pulse output
`timescale 1ns/100ps
`default_nettype none
interface dpt_pwm_if;
  import dpt_pkg::*;
  // New period begins (one-cycle pulse)
  logic wrap;
  // Time-base count extended by phase bits
  logic [DUTY_BITS-1:0] pos;
  // Written duty value
  logic [DUTY_BITS-1:0] duty_master;
  // Duty value in use this period
  logic [DUTY_BITS-1:0] duty_active;
  // Pulse level
  logic level;
  modport chan (input wrap, input pos, input duty_master, output duty_active, output level);
  modport core (output wrap, output pos, output duty_master, input duty_active, input level);
endinterface : dpt_pwm_if
`default_nettype wire

// *** rtl/dpt_pwm_chan.sv ***
// Purpose: One double-buffered pulse width channel
// Assumes: pos advances once per hclk within a period
// Notes: Level and active duty come from flip-flops
`timescale 1ns/100ps
`default_nettype none
module dpt_pwm_chan
  import dpt_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  dpt_pwm_if.chan bus
);

  // Channel state
  typedef struct packed {
    logic [DUTY_BITS-1:0] active;
    logic level;
  } dpt_chan_s;

  dpt_chan_s s_reg;
  dpt_chan_s s_next;
  logic [DUTY_BITS-1:0] use_duty;

  // Latch transfer and compare
  always_comb
  begin
    s_next = s_reg;
    // master to active only at wrap
    use_duty = bus.wrap ? bus.duty_master : s_reg.active;
    s_next.active = use_duty;
    s_next.level = (bus.pos < use_duty);
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_reg <= '{active: RST_DUTY, level: 1'b0};
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign bus.duty_active = s_reg.active;
  assign bus.level = s_reg.level;

endmodule : dpt_pwm_chan
`default_nettype wire

// *** testbench/dpt_timer_monitor.sv ***
// Purpose: Port-level checks for the dual period timer
// Assumes: Sees top ports only; mirrors control writes
// Notes: Pin and interrupt checks use one or two cycles of lag
`timescale 1ns/100ps
`default_nettype none
module dpt_timer_monitor
  import dpt_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic pulse1_pin_out,
  input wire logic pulse1_pin_oe,
  input wire logic pulse2_pin_out,
  input wire logic pulse2_pin_oe,
  input wire logic irq_req
);
  // Pending write and its address
  logic wr_pend;
  logic [8:0] wr_addr;
  // Mirrors of config, direction, port data, misc, core, enables
  logic [7:0] tcfg_s, dir_s, pd_s, misc_s, core_s, pen_s;
  wire logic rd_req = hsel & htrans[1] & hready & ~hwrite;
  wire logic oe1_exp = tcfg_s[4] | ~dir_s[2];
  wire logic oe2_exp = tcfg_s[5] | ~dir_s[3];
  wire logic irq_ok = core_s[3] & ~misc_s[4] & (|pen_s[5:4]);
  // Mirror control writes at the end of their data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 9'h000;
      tcfg_s <= 8'h00;
      dir_s <= 8'hff;
      pd_s <= 8'h00;
      misc_s <= 8'h00;
      core_s <= 8'h00;
      pen_s <= 8'h00;
    end
    else if (hready)
    begin
      wr_pend <= hsel & htrans[1] & hwrite & (hsize == HSIZE_WORD)
        & (haddr[31:9] == 23'h0) & (haddr[1:0] == 2'h0);
      wr_addr <= haddr[8:0];
      if (wr_pend)
      begin
        case (wr_addr)
          9'h1dc: tcfg_s <= hwdata[7:0];
          9'h020: dir_s <= hwdata[7:0];
          9'h024: pd_s <= hwdata[7:0];
          9'h018: misc_s <= hwdata[7:0];
          9'h01c: core_s <= hwdata[7:0];
          9'h0dc: pen_s <= hwdata[7:0];
          default: ;
        endcase
      end
    end
  end
  default clocking mcb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ready_high_a: assert property (hreadyout) else $error("hreadyout low");
  resp_okay_a: assert property (!hresp) else $error("hresp set");
  rdata_upper_a: assert property (hrdata[31:8] == 24'h0) else $error("hrdata high bits");
  rdata_hold_a: assert property (!$past(rd_req) |-> $stable(hrdata))
    else $error("hrdata moved");
  oe1_follow_a: assert property (pulse1_pin_oe == $past(oe1_exp))
    else $error("pin1 oe wrong");
  oe2_follow_a: assert property (pulse2_pin_oe == $past(oe2_exp))
    else $error("pin2 oe wrong");
  port1_out_a: assert property (!$past(tcfg_s[4]) |-> pulse1_pin_out == $past(pd_s[2]))
    else $error("pin1 not port data");
  irq_gate_a: assert property (irq_req |-> $past(irq_ok, 2) || $past(irq_ok))
    else $error("irq without enables");
  irq_seen_c: cover property ($rose(irq_req));
  pulse_seen_c: cover property (pulse1_pin_oe && $rose(pulse1_pin_out));
  read_seen_c: cover property (rd_req);
endmodule : dpt_timer_monitor
bind dpt_timer_top dpt_timer_monitor dpt_timer_monitor_inst (.*);
`default_nettype wire

// *** testbench/dpt_far_side.sv ***
// Purpose: Count clock source and pin loads
// Assumes: Pins pulled up when undriven
// Notes: Count pin idles high; one falling edge per request
`timescale 1ns/100ps
`default_nettype none
module dpt_far_side
(
  input wire logic hclk,
  input wire logic edge_req,
  input wire logic [3:0] low_len,
  input wire logic pulse1_pin_out,
  input wire logic pulse1_pin_oe,
  input wire logic pulse2_pin_out,
  input wire logic pulse2_pin_oe,
  output logic count_pin_in,
  output logic pulse1_pin_in,
  output logic pulse2_pin_in
);
  // Cycles left in the low phase
  logic [3:0] low_cnt = 4'h0;
  initial count_pin_in = 1'b1;
  // Low for low_len cycles, then back to idle high
  always @(posedge hclk)
  begin
    if (edge_req)
    begin
      count_pin_in <= 1'b0;
      low_cnt <= low_len;
    end
    else if (low_cnt > 4'h1)
      low_cnt <= low_cnt - 4'h1;
    else
      count_pin_in <= 1'b1;
  end
  // Pull-ups on undriven pins
  assign pulse1_pin_in = pulse1_pin_oe ? pulse1_pin_out : 1'b1;
  assign pulse2_pin_in = pulse2_pin_oe ? pulse2_pin_out : 1'b1;
endmodule : dpt_far_side
`default_nettype wire

// *** testbench/tb_dual_period_timer_pwm_pins.sv ***
// Purpose: Self-checking bench for the dual period timer
// Assumes: Zero wait-state slave; byte address = word address * 4
// Notes: Timings checked in single hclk cycles, not whole instruction cycles
`timescale 1ns/100ps
`default_nettype none
module tb_dual_period_timer_pwm_pins;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq_req, edge_req;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] low_len;
  logic count_pin_in, pulse1_pin_in, pulse1_pin_out, pulse1_pin_oe;
  logic pulse2_pin_in, pulse2_pin_out, pulse2_pin_oe;
  int fail_count = 0;
  int tests_run = 0;
  assign hready = hreadyout;
  dpt_timer_top dpt_timer_top_inst (.*);
  dpt_far_side dpt_far_side_inst (.*);
  // 200 MHz clock
  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  task automatic report_and_stop();
    if (fail_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One single word transfer; read data taken at the data phase edge
  task automatic bus(input logic w, input logic [8:0] a, input logic [7:0] d,
    output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {23'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask : bus
  // High cycles of one pulse pin over 64 cycles
  task automatic count_high(input logic which, output int n);
    n = 0;
    repeat (64)
    begin
      @(posedge hclk);
      n += (which ? pulse2_pin_in : pulse1_pin_in);
    end
  endtask : count_high
  // Reset values, unmapped space, read-zero config bits
  task automatic t_regs();
    logic [31:0] q;
    logic [8:0] ra [8];
    ra = '{9'h01c, 9'h0d8, 9'h0dc, 9'h1d8, 9'h1dc, 9'h140, 9'h150, 9'h100};
    bus(1'b1, 9'h100, 8'hff, q);
    foreach (ra[i])
    begin
      bus(1'b0, ra[i], 8'h00, q);
      chk("reset value", (i == 1) ? 32'h2 : 32'h0, q);
    end
    bus(1'b1, 9'h1dc, 8'hff, q);
    bus(1'b0, 9'h1dc, 8'h00, q);
    chk("config b bits", 32'h3f, q);
    bus(1'b1, 9'h1dc, 8'h00, q);
  endtask : t_regs
  // Each timer alone: step, wrap, flag, hold
  task automatic t_timers();
    logic [31:0] q, c0;
    for (int i = 0; i < 2; i++)
    begin
      bus(1'b1, 9'h1dc, 8'h00, q);
      bus(1'b1, 9'h150 + 9'(4 * i), 8'h04, q);
      bus(1'b1, 9'h140 + 9'(4 * i), 8'h00, q);
      bus(1'b1, 9'h0d8, 8'h00, q);
      bus(1'b1, 9'h1dc, 8'h01 << i, q);
      bus(1'b0, 9'h140 + 9'(4 * i), 8'h00, c0);
      repeat (5) @(posedge hclk);
      bus(1'b0, 9'h140 + 9'(4 * i), 8'h00, q);
      chk("count step", (c0 + 32'h2) % 32'h5, q);
      repeat (24) @(posedge hclk);
      bus(1'b0, 9'h0d8, 8'h00, q);
      chk("own flag", 32'h10 << i, q & 32'h30);
      bus(1'b1, 9'h1dc, 8'h00, q);
      bus(1'b1, 9'h0d8, 8'h00, q);
      bus(1'b0, 9'h140 + 9'(4 * i), 8'h00, c0);
      repeat (40) @(posedge hclk);
      bus(1'b0, 9'h140 + 9'(4 * i), 8'h00, q);
      chk("stopped count", c0, q);
      bus(1'b0, 9'h0d8, 8'h00, q);
      chk("stopped flag", 32'h0, q & 32'h30);
    end
  endtask : t_timers
  // All enable combinations with the first flag set
  task automatic t_irq();
    logic [31:0] q;
    bus(1'b1, 9'h1dc, 8'h01, q);
    repeat (30) @(posedge hclk);
    for (int k = 0; k < 8; k++)
    begin
      bus(1'b1, 9'h0dc, k[0] ? 8'h10 : 8'h00, q);
      bus(1'b1, 9'h01c, k[1] ? 8'h08 : 8'h00, q);
      bus(1'b1, 9'h018, k[2] ? 8'h10 : 8'h00, q);
      repeat (4) @(posedge hclk);
      chk("irq", {31'h0, k[0] & k[1] & ~k[2]}, {31'h0, irq_req});
    end
    bus(1'b1, 9'h0dc, 8'h00, q);
    bus(1'b1, 9'h1dc, 8'h00, q);
  endtask : t_irq
  // Cascaded pair: carry, 16-bit match, low byte alone
  task automatic t_cascade();
    logic [31:0] q;
    bus(1'b1, 9'h1d8, 8'h0a, q);
    bus(1'b1, 9'h150, 8'h02, q);
    bus(1'b1, 9'h154, 8'h01, q);
    bus(1'b1, 9'h140, 8'hff, q);
    bus(1'b1, 9'h144, 8'h00, q);
    bus(1'b1, 9'h0d8, 8'h00, q);
    bus(1'b1, 9'h1dc, 8'h03, q);
    repeat (6) @(posedge hclk);
    bus(1'b0, 9'h144, 8'h00, q);
    chk("carry to high byte", 32'h1, q);
    repeat (12) @(posedge hclk);
    bus(1'b0, 9'h144, 8'h00, q);
    chk("high byte after match", 32'h0, q);
    bus(1'b0, 9'h0d8, 8'h00, q);
    chk("cascade flag", 32'h10, q & 32'h30);
    bus(1'b1, 9'h1dc, 8'h00, q);
    bus(1'b1, 9'h140, 8'hff, q);
    bus(1'b1, 9'h144, 8'h00, q);
    bus(1'b1, 9'h1dc, 8'h01, q);
    repeat (12) @(posedge hclk);
    bus(1'b0, 9'h144, 8'h00, q);
    chk("low byte alone", 32'h0, q);
    bus(1'b1, 9'h1dc, 8'h00, q);
  endtask : t_cascade
  // Falling edges on the count pin, prompt and slow
  task automatic edges(input int n, input logic [3:0] len);
    repeat (n)
    begin
      edge_req <= 1'b1;
      low_len <= len;
      @(posedge hclk);
      edge_req <= 1'b0;
      repeat (2 * len + 8) @(posedge hclk);
    end
  endtask : edges
  task automatic t_external();
    logic [31:0] q;
    bus(1'b1, 9'h1d8, 8'h01, q);
    bus(1'b1, 9'h150, 8'hff, q);
    bus(1'b1, 9'h140, 8'h00, q);
    bus(1'b1, 9'h1dc, 8'h01, q);
    @(posedge hclk);
    edges(3, 4'h5);
    bus(1'b0, 9'h140, 8'h00, q);
    chk("prompt edges", 32'h3, q);
    edges(3, 4'hc);
    bus(1'b0, 9'h140, 8'h00, q);
    chk("slow edges", 32'h6, q);
    bus(1'b1, 9'h1dc, 8'h00, q);
    bus(1'b1, 9'h140, 8'h00, q);
    bus(1'b1, 9'h1d8, 8'h09, q);
    bus(1'b1, 9'h1dc, 8'h03, q);
    @(posedge hclk);
    edges(1, 4'h3);
    bus(1'b0, 9'h140, 8'h00, q);
    chk("cascade short edge", 32'h1, q);
    bus(1'b1, 9'h1dc, 8'h00, q);
    bus(1'b1, 9'h1d8, 8'h00, q);
  endtask : t_external
  // Duty range, buffering, second time-base, pin ownership
  task automatic t_pwm();
    logic [31:0] q;
    int n;
    logic [7:0] hi [3];
    logic [7:0] lo [3];
    int ex [3];
    hi = '{8'h00, 8'h01, 8'h04};
    lo = '{8'h00, 8'h80, 8'h00};
    ex = '{0, 24, 64};
    bus(1'b1, 9'h150, 8'h03, q);
    bus(1'b1, 9'h140, 8'h00, q);
    bus(1'b1, 9'h1dc, 8'h11, q);
    repeat (2) @(posedge hclk);
    chk("pin1 forced out", 32'h1, {31'h0, pulse1_pin_oe});
    foreach (hi[j])
    begin
      bus(1'b1, 9'h1c8, hi[j], q);
      bus(1'b1, 9'h1c0, lo[j], q);
      repeat (40) @(posedge hclk);
      count_high(1'b0, n);
      chk("pulse1 high time", ex[j], n);
    end
    bus(1'b1, 9'h1dc, 8'h10, q);
    bus(1'b1, 9'h1c8, 8'h02, q);
    bus(1'b0, 9'h1c8, 8'h00, q);
    chk("active duty read", 32'h04, q);
    bus(1'b1, 9'h154, 8'h01, q);
    bus(1'b1, 9'h1cc, 8'h01, q);
    bus(1'b1, 9'h1c4, 8'h20, q);
    bus(1'b1, 9'h1dc, 8'h33, q);
    repeat (40) @(posedge hclk);
    count_high(1'b1, n);
    chk("pulse2 on second", 32'd32, n);
    bus(1'b1, 9'h1c4, 8'h00, q);
    repeat (40) @(posedge hclk);
    count_high(1'b1, n);
    chk("pulse2 on first", 32'd16, n);
    bus(1'b1, 9'h1dc, 8'h03, q);
    repeat (3) @(posedge hclk);
    chk("pin2 released", 32'h0, {31'h0, pulse2_pin_oe});
    bus(1'b1, 9'h020, 8'h00, q);
    bus(1'b1, 9'h024, 8'h08, q);
    repeat (3) @(posedge hclk);
    chk("pin levels", 32'h2, {30'h0, pulse2_pin_in, pulse1_pin_in});
  endtask : t_pwm
  // Main sequence
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    edge_req = 1'b0;
    low_len = 4'h4;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_timers();
    t_irq();
    t_cascade();
    t_external();
    t_pwm();
    report_and_stop();
  end
  // Hang guard
  initial
  begin
    repeat (20000) @(posedge hclk);
    fail_count++;
    $display("[FAIL] watchdog expected finish seen timeout");
    report_and_stop();
  end
endmodule : tb_dual_period_timer_pwm_pins
`default_nettype wire
